/* File: eeelpi_pkg.sv */
// Package with constants and carriers for the EEE low power idle control block
// Notes on behaviour
// R1: Transmit and receive LPI are tracked separately at 100 Mb/s.
// R2: EEE works at 10 and 100; 10 Mb/s uses reduced amplitude, no LPI. Code blocks only transmit LPI at 10 Mb/s; receive LPI is still detected.
// R3: Gate unused MAC and switch clocks while in low power idle.
// R4: Entering or leaving LPI keeps link up and loses no frame.
// R5: Switch logic requests LPI; request goes to PHY over the MII.
// R6: MAC is full duplex but defers on carrier sense while in LPI.
// R7: On LPI request, drive assert-LPI encoding at once and block MAC traffic.
// R8: On request removal, send normal idle and hold MAC off for a wake delay.
// R9: Without assert-LPI on receive MII, pass receive signals through unchanged.
// R10: On entering receive LPI, keep reporting idle and raise partner idle.
// R11: On leaving receive LPI, drop partner idle and resume normal decoding.
// R12: PHY sends sleep for 200 to 220 us, then goes quiet.
// R13: At 100 Mb/s, quiet about 20 to 22 ms, refresh 200 to 220 us.
// R14: Repeat quiet and refresh until normal idle, then send wake for fixed time.
// R15: On partner sleep, present assert-LPI on receive MII; may power down receiver.
// R16: Partner ends LPI with wake; then receive MII returns to normal idle.
// R17: EEE enabled only when both ends advertise it for resolved type.
// R18: Without resolved EEE, disable all EEE functions and never request LPI.
// R19: With EEE resolved, transmit and receive LPI act independently.
// R20: Resolution reruns at reset, management command, link failure or user request.
// R21: Assert-LPI starts only between frames, never truncating a frame.
// R22: Wake delay held in configurable counter, cleared on each new request.
package eeelpi_pkg;
   // MII nibble and control carrier
   typedef struct packed {
      logic       en;
      logic       er;
      logic [3:0] d;
   } eeelpi_mii_t;

   // Assert-LPI encoding: enable low, error high, data 0001
   localparam logic [3:0] LPI_CODE    = 4'h1;
   localparam int         CLK_HZ      = 10_000_000;
   localparam int         SLEEP_US    = 200;
   localparam int         QUIET_US    = 20_000;
   localparam int         REFRESH_US  = 200;
   localparam int         WAKE_US     = 30;
   localparam int         SLEEP_CYC   = (SLEEP_US * (CLK_HZ / 1_000_000));
   localparam int         QUIET_CYC   = (QUIET_US * (CLK_HZ / 1_000_000));
   localparam int         REFRESH_CYC = (REFRESH_US * (CLK_HZ / 1_000_000));
   localparam int         WAKE_CYC    = (WAKE_US * (CLK_HZ / 1_000_000));
   localparam int         CNT_W       = 20;

   // PHY transmit LPI sequencer states, Gray coded in listed order from active to wake
   typedef enum logic [2:0] {
      EEELPI_ACTIVE  = 3'b000,
      EEELPI_SLEEP   = 3'b001,
      EEELPI_QUIET   = 3'b011,
      EEELPI_REFRESH = 3'b010,
      EEELPI_WAKE    = 3'b110
   } eeelpi_state_t;
endpackage

/* File: eeelpi_ctrl.sv */
// EEE low power idle transmit, detect and PHY sequencing logic
`timescale 1ns/1ps
module eeelpi_ctrl #(
   parameter int QUIET_CYCLES = eeelpi_pkg::QUIET_CYC,
   parameter int WAKE_CYCLES  = eeelpi_pkg::WAKE_CYC
) (
   input  wire logic                    clk_in,
   input  wire logic                    resetn_in,
   input  wire logic                    speed100_in,
   input  wire logic                    local_adv_in,
   input  wire logic                    partner_adv_in,
   input  wire logic                    an_done_in,
   input  wire logic                    lpi_request_in,
   input  wire eeelpi_pkg::eeelpi_mii_t mac_tx_in,
   input  wire eeelpi_pkg::eeelpi_mii_t phy_rx_in,
   input  wire logic                    link_clk_in,
   input  wire logic                    partner_sleep_in,
   input  wire logic                    partner_wake_in,
   output eeelpi_pkg::eeelpi_mii_t      phy_tx_out,
   output eeelpi_pkg::eeelpi_mii_t      mac_rx_out,
   output logic                         mac_tx_hold_out,
   output logic                         carrier_defer_out,
   output logic                         partner_low_power_indication_out,
   output logic                         eee_active_out,
   output logic                         clk_gate_out,
   output logic                         reduced_amp_out,
   output eeelpi_pkg::eeelpi_state_t    phy_tx_state_out,
   output logic                         line_tx_on_out,
   output logic                         rx_powerdown_out
);
   logic                      eee_ok;
   logic [1:0]                req_sync;
   logic [1:0]                sleep_sync;
   logic [1:0]                wake_sync;
   logic [1:0]                lclk_sync;
   logic                      lclk_prev;
   logic                      lclk_rise;
   logic                      req;
   logic                      tx_lpi;
   logic                      in_frame;
   logic [eeelpi_pkg::CNT_W-1:0] wake_cnt;
   eeelpi_pkg::eeelpi_state_t state;
   eeelpi_pkg::eeelpi_state_t next_state;
   logic [eeelpi_pkg::CNT_W-1:0] seq_cnt;
   logic                      rx_lpi;
   logic                      rx_asleep;
   eeelpi_pkg::eeelpi_mii_t   rx_q;

   // Detects the assert-LPI pattern on an MII nibble group
   function automatic logic is_lpi(input eeelpi_pkg::eeelpi_mii_t m);
      return !m.en && m.er && (m.d == eeelpi_pkg::LPI_CODE);
   endfunction

   // Duration of each sequencer state in cycles
   function automatic logic [eeelpi_pkg::CNT_W-1:0] dur(input eeelpi_pkg::eeelpi_state_t s);
      case (s)
         eeelpi_pkg::EEELPI_SLEEP:   dur = eeelpi_pkg::CNT_W'(eeelpi_pkg::SLEEP_CYC);
         eeelpi_pkg::EEELPI_QUIET:   dur = eeelpi_pkg::CNT_W'(QUIET_CYCLES);
         eeelpi_pkg::EEELPI_REFRESH: dur = eeelpi_pkg::CNT_W'(eeelpi_pkg::REFRESH_CYC);
         default:                    dur = eeelpi_pkg::CNT_W'(WAKE_CYCLES);
      endcase
   endfunction

   // EEE resolved only if both ends advertise and negotiation is done, at either speed
   assign eee_ok          = an_done_in && local_adv_in && partner_adv_in; // R17 R20
   assign reduced_amp_out = eee_ok && !speed100_in; // R2

   // Two-stage synchronisers for pins from outside the clock domain
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         req_sync   <= 2'h0;
         sleep_sync <= 2'h0;
         wake_sync  <= 2'h0;
         lclk_sync  <= 2'h0;
         lclk_prev  <= 1'b0;
      end else begin
         req_sync   <= {req_sync[0], lpi_request_in};
         sleep_sync <= {sleep_sync[0], partner_sleep_in};
         wake_sync  <= {wake_sync[0], partner_wake_in};
         lclk_sync  <= {lclk_sync[0], link_clk_in};
         lclk_prev  <= lclk_sync[1];
      end
   end
   assign lclk_rise = lclk_sync[1] && !lclk_prev;

   // Request gated by EEE resolution and speed
   assign req = req_sync[1] && eee_ok && speed100_in; // R5 R18

   // Frame tracking so LPI starts only between frames
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         in_frame <= 1'b0;
      end else if (lclk_rise) begin
         in_frame <= mac_tx_in.en;
      end
   end

   // Transmit LPI state, entered only when no frame is in flight
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_lpi <= 1'b0;
      end else if (!req) begin
         tx_lpi <= 1'b0; // R8
      end else if (!in_frame && !mac_tx_in.en) begin
         tx_lpi <= 1'b1; // R7 R21
      end
   end

   // Wake delay counter, loaded on the edge LPI ends so hold never dips
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_cnt <= '0;
      end else if (req) begin
         wake_cnt <= '0; // R22
      end else if (tx_lpi) begin
         wake_cnt <= eeelpi_pkg::CNT_W'(WAKE_CYCLES); // R8
      end else if (wake_cnt != '0) begin
         wake_cnt <= wake_cnt - 1'b1;
      end
   end

   // MAC hold and carrier deferral while transmit LPI or waking
   assign mac_tx_hold_out   = tx_lpi || (wake_cnt != '0); // R6 R8 R4
   assign carrier_defer_out = mac_tx_hold_out; // R6
   assign clk_gate_out      = tx_lpi && rx_lpi; // R3
   assign eee_active_out    = tx_lpi; // R1

   // Transmit MII output register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phy_tx_out <= '0;
      end else if (tx_lpi) begin
         phy_tx_out <= '{en: 1'b0, er: 1'b1, d: eeelpi_pkg::LPI_CODE}; // R7
      end else if (wake_cnt != '0) begin
         phy_tx_out <= '0; // R8
      end else begin
         phy_tx_out <= mac_tx_in;
      end
   end

   // PHY transmit sequencer: sleep, quiet, refresh, wake
   always_comb begin
      next_state = state;
      case (state)
         eeelpi_pkg::EEELPI_ACTIVE: begin
            if (tx_lpi) begin
               next_state = eeelpi_pkg::EEELPI_SLEEP; // R12
            end
         end
         eeelpi_pkg::EEELPI_SLEEP: begin
            if (seq_cnt == '0) begin
               next_state = tx_lpi ? eeelpi_pkg::EEELPI_QUIET : eeelpi_pkg::EEELPI_WAKE;
            end
         end
         eeelpi_pkg::EEELPI_QUIET: begin
            if (!tx_lpi) begin
               next_state = eeelpi_pkg::EEELPI_WAKE; // R14
            end else if (seq_cnt == '0) begin
               next_state = eeelpi_pkg::EEELPI_REFRESH; // R13
            end
         end
         eeelpi_pkg::EEELPI_REFRESH: begin
            if (seq_cnt == '0) begin
               next_state = tx_lpi ? eeelpi_pkg::EEELPI_QUIET : eeelpi_pkg::EEELPI_WAKE;
            end
         end
         eeelpi_pkg::EEELPI_WAKE: begin
            if (seq_cnt == '0) begin
               next_state = eeelpi_pkg::EEELPI_ACTIVE; // R14
            end
         end
         default: next_state = eeelpi_pkg::EEELPI_ACTIVE;
      endcase
   end

   // Sequencer state and per-state counter
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state   <= eeelpi_pkg::EEELPI_ACTIVE;
         seq_cnt <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            seq_cnt <= dur(next_state) - 1'b1;
         end else if (seq_cnt != '0) begin
            seq_cnt <= seq_cnt - 1'b1;
         end
      end
   end
   assign phy_tx_state_out = state;
   assign line_tx_on_out   = (state != eeelpi_pkg::EEELPI_QUIET); // R12 R13

   // Receive side: partner sleep enters LPI, wake leaves it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_asleep <= 1'b0;
      end else if (!eee_ok || wake_sync[1]) begin
         rx_asleep <= 1'b0; // R16 R18
      end else if (sleep_sync[1]) begin
         rx_asleep <= 1'b1; // R15
      end
   end
   assign rx_powerdown_out = rx_asleep; // R15

   // Receive LPI detect, independent of transmit side
   assign rx_lpi = eee_ok && (is_lpi(phy_rx_in) || rx_asleep); // R19 R1

   // Receive MII mapping to the MAC
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_q                             <= '0;
         partner_low_power_indication_out <= 1'b0;
      end else if (rx_lpi) begin
         rx_q                             <= '0; // R10
         partner_low_power_indication_out <= 1'b1; // R10
      end else begin
         rx_q                             <= phy_rx_in; // R9 R11
         partner_low_power_indication_out <= 1'b0; // R11
      end
   end
   assign mac_rx_out = rx_q;

   // Without resolved EEE no transmit LPI ever appears
   property p_no_lpi_without_eee;
      @(posedge clk_in) disable iff (!resetn_in)
      !eee_ok |=> !tx_lpi;
   endproperty
   a_no_lpi_without_eee: assert property (p_no_lpi_without_eee) // R18
      else $error("LPI active without EEE");

   // LPI encoding follows transmit LPI one cycle later
   property p_lpi_code;
      @(posedge clk_in) disable iff (!resetn_in)
      tx_lpi |=> (phy_tx_out.er && !phy_tx_out.en && phy_tx_out.d == eeelpi_pkg::LPI_CODE);
   endproperty
   a_lpi_code: assert property (p_lpi_code) // R7
      else $error("LPI encoding missing");

   // No MAC traffic reaches the transmit MII while held
   property p_hold_in_lpi;
      @(posedge clk_in) disable iff (!resetn_in)
      mac_tx_hold_out |-> carrier_defer_out ##1 !phy_tx_out.en;
   endproperty
   a_hold_in_lpi: assert property (p_hold_in_lpi) // R6
      else $error("MAC not held in LPI");

   // Wake delay holds MAC after leaving LPI
   property p_wake_hold;
      @(posedge clk_in) disable iff (!resetn_in)
      $fell(tx_lpi) |-> mac_tx_hold_out ##1 mac_tx_hold_out;
   endproperty
   a_wake_hold: assert property (p_wake_hold) // R8
      else $error("No wake hold after LPI");

   // LPI never begins mid frame
   property p_no_truncate;
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(tx_lpi) |-> !$past(in_frame);
   endproperty
   a_no_truncate: assert property (p_no_truncate) // R21
      else $error("LPI started within frame");

   // Sleep follows LPI entry
   property p_sleep_after_lpi;
      @(posedge clk_in) disable iff (!resetn_in)
      (state == eeelpi_pkg::EEELPI_ACTIVE && tx_lpi) |=> state == eeelpi_pkg::EEELPI_SLEEP;
   endproperty
   a_sleep_after_lpi: assert property (p_sleep_after_lpi) // R12
      else $error("Sleep not sent");

   // Partner idle tracks detection one cycle later
   property p_partner_idle;
      @(posedge clk_in) disable iff (!resetn_in)
      rx_lpi |=> partner_low_power_indication_out && mac_rx_out == '0;
   endproperty
   a_partner_idle: assert property (p_partner_idle) // R10
      else $error("Partner idle not raised");

   // Normal receive data passes through
   property p_rx_pass;
      @(posedge clk_in) disable iff (!resetn_in)
      !rx_lpi |=> !partner_low_power_indication_out && mac_rx_out == $past(phy_rx_in);
   endproperty
   a_rx_pass: assert property (p_rx_pass) // R9
      else $error("Receive not passed through");
endmodule

/* File: eeelpi_partner.sv */
// Far-side PHY receive model: sleep, assert-LPI, wake and frames
`timescale 1ns/1ps
module eeelpi_partner #(
   parameter int SIGC = 20
) (
   input  wire logic               clk_in,
   input  wire logic               lpi_in,
   input  wire logic               frame_in,
   output eeelpi_pkg::eeelpi_mii_t rx_out,
   output logic                    sleep_out,
   output logic                    wake_out
);
   logic [7:0] cnt    = 8'h00;
   logic [3:0] beat   = 4'h0;
   logic       lpi_d  = 1'b0;
   logic       in_lpi = 1'b0;
   // Phase counter restarts on each change of the LPI command
   always @(posedge clk_in) begin
      lpi_d <= lpi_in;
      beat  <= beat + 4'h1;
      cnt   <= (lpi_in != lpi_d) ? 8'h00 : ((cnt == 8'hff) ? cnt : cnt + 8'h01);
      sleep_out <= lpi_in && (int'(cnt) < SIGC);
      wake_out  <= !lpi_in && in_lpi && (int'(cnt) < SIGC);
      if (int'(cnt) >= SIGC && lpi_d == lpi_in) begin
         in_lpi <= lpi_in;
      end
   end
   // Receive MII: assert-LPI, frame nibbles, or a changing idle pattern
   always @(posedge clk_in) begin
      if (in_lpi) begin
         rx_out <= '{en: 1'b0, er: 1'b1, d: eeelpi_pkg::LPI_CODE};
      end else begin
         rx_out <= '{en: frame_in, er: 1'b0, d: frame_in ? beat : ~beat};
      end
   end
endmodule

/* File: eee_low_power_idle_control_tb_top.sv */
// Testbench for the EEE low power idle control block
`timescale 1ns/1ps
module eee_low_power_idle_control_tb_top;
   localparam int QC = 50;
   localparam int WC = 5;
   logic                      clk, rstn, spd, ladv, padv, an, req, lclk, plpi, pfrm;
   logic                      sleep, wake, hold, defer, pli, act, gate, ramp, lon, rxpd;
   eeelpi_pkg::eeelpi_mii_t   mtx, prx, ptx, mrx, p;
   eeelpi_pkg::eeelpi_state_t st;
   int                        err_total = 0;
   int                        samples_checked = 0;

   eeelpi_ctrl #(.QUIET_CYCLES(QC), .WAKE_CYCLES(WC)) eeelpi_ctrl_inst (
      .clk_in(clk), .resetn_in(rstn), .speed100_in(spd), .local_adv_in(ladv),
      .partner_adv_in(padv), .an_done_in(an), .lpi_request_in(req), .mac_tx_in(mtx),
      .phy_rx_in(prx), .link_clk_in(lclk), .partner_sleep_in(sleep),
      .partner_wake_in(wake), .phy_tx_out(ptx), .mac_rx_out(mrx), .mac_tx_hold_out(hold),
      .carrier_defer_out(defer), .partner_low_power_indication_out(pli),
      .eee_active_out(act), .clk_gate_out(gate), .reduced_amp_out(ramp),
      .phy_tx_state_out(st), .line_tx_on_out(lon), .rx_powerdown_out(rxpd));

   eeelpi_partner eeelpi_partner_inst (
      .clk_in(clk), .lpi_in(plpi), .frame_in(pfrm), .rx_out(prx),
      .sleep_out(sleep), .wake_out(wake));

   // Clock, and a free-running MII link clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always #400 lclk = ~lclk;

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   // Cycles until the sequencer reaches a state
   task automatic wait_st(input eeelpi_pkg::eeelpi_state_t s, output int n);
      n = 0;
      while (st !== s && n < 30000) begin
         step(1);
         n++;
      end
   endtask

   task automatic wait_hold_low(output int k);
      k = 0;
      while (hold === 1'b1 && k < 200) begin
         step(1);
         k++;
      end
   endtask

   // Full transmit LPI cycle: sleep, quiet, refresh, wake
   task automatic t_tx;
      int n;
      req = 1'b1;
      step(5);
      chk(ptx === eeelpi_pkg::eeelpi_mii_t'{en: 1'b0, er: 1'b1, d: eeelpi_pkg::LPI_CODE},
          "no lpi code");
      chk(hold === 1'b1 && defer === 1'b1 && act === 1'b1, "mac not held");
      wait_st(eeelpi_pkg::EEELPI_QUIET, n);
      chk(n >= 1990 && n <= 2200 && lon === 1'b0, "sleep span");
      wait_st(eeelpi_pkg::EEELPI_REFRESH, n);
      chk(n >= QC - 1 && n <= QC + 1 && lon === 1'b1, "quiet span");
      wait_st(eeelpi_pkg::EEELPI_QUIET, n);
      chk(n >= 1990 && n <= 2200, "refresh span");
      req = 1'b0;
      wait_st(eeelpi_pkg::EEELPI_WAKE, n);
      chk(n <= QC + 2210 && ptx.er === 1'b0 && ptx.en === 1'b0, "no idle");
      n = 0;
      while (act === 1'b1 && n < 10) begin
         step(1);
         n++;
      end
      wait_hold_low(n);
      chk(n >= WC - 1 && n <= WC + 1, "wake delay");
      wait_st(eeelpi_pkg::EEELPI_ACTIVE, n);
      chk(n <= 100 && defer === 1'b0, "wake not ended");
      $display("done tx");
   endtask

   // Receive LPI while transmit also idles, then partner wakes
   task automatic t_rx;
      int k;
      req = 1'b1;
      pfrm = 1'b1;
      step(6);
      repeat (4) begin
         p = prx;
         step(1);
         chk(mrx === p, "rx not passed");
      end
      chk(gate === 1'b0 && pli === 1'b0, "early gate");
      pfrm = 1'b0;
      plpi = 1'b1;
      k = 0;
      while (pli !== 1'b1 && k < 60) begin
         step(1);
         k++;
      end
      chk(pli === 1'b1 && mrx.en === 1'b0 && mrx.er === 1'b0, "rx lpi");
      chk(rxpd === 1'b1 && gate === 1'b1, "no power save");
      k = 0;
      while (prx.er !== 1'b1 && k < 60) begin
         step(1);
         k++;
      end
      chk(pli === 1'b1 && mrx === '0, "rx lpi code not idle");
      plpi = 1'b0;
      step(60);
      chk(pli === 1'b0 && gate === 1'b0, "lpi stuck");
      pfrm = 1'b1;
      step(2);
      p = prx;
      step(1);
      chk(mrx === p, "decode not resumed");
      pfrm = 1'b0;
      req = 1'b0;
      wait_hold_low(k);
      $display("done rx");
   endtask

   // Renegotiation ends LPI, then request with each EEE or speed condition missing in turn
   task automatic t_noeee;
      int k;
      req = 1'b1;
      step(5);
      chk(act === 1'b1, "no lpi before renegotiation");
      an = 1'b0;
      step(2);
      chk(act === 1'b0 && hold === 1'b1 && ptx.er === 1'b0, "lpi kept");
      wait_hold_low(k);
      chk(k >= WC - 1 && k <= WC + 1, "renegotiation wake delay");
      for (int i = 0; i < 4; i++) begin
         {ladv, padv, an, spd} = 4'hf ^ (4'h8 >> i);
         step(8);
         chk(act === 1'b0 && hold === 1'b0 && ptx.er === 1'b0, "lpi sent");
      end
      chk(ramp === 1'b1, "no reduced amplitude");
      req = 1'b0;
      step(4);
      {ladv, padv, an, spd} = 4'hf;
      wait_hold_low(k);
      $display("done noeee");
   endtask

   // Request during a frame waits for its end
   task automatic t_frame;
      int k;
      mtx = '{en: 1'b1, er: 1'b0, d: 4'h0};
      req = 1'b1;
      repeat (10) begin
         mtx.d = mtx.d + 4'h1;
         p = mtx;
         step(1);
         chk(ptx === p, "frame cut");
      end
      mtx = '0;
      step(14);
      chk(ptx.er === 1'b1 && act === 1'b1, "lpi missing");
      req = 1'b0;
      wait_hold_low(k);
      $display("done frame");
   endtask

   initial begin
      {rstn, req, lclk, plpi, pfrm} = 5'h00;
      {ladv, padv, an, spd} = 4'hf;
      mtx = '0;
      repeat (20) @(posedge clk);
      #10;
      rstn = 1'b1;
      step(1);
      chk(st === eeelpi_pkg::EEELPI_ACTIVE && ptx === '0 && act === 1'b0, "reset");
      t_tx();
      t_rx();
      t_noeee();
      t_frame();
      finish_test();
   end

   // Watchdog well past the expected run length
   initial begin
      #2000000;
      err_total++;
      $display("BAD %0t timeout", $time);
      finish_test();
   end
endmodule
